/* core/i2c_smbus_data_address_timeout.sv */
// data port, address modes and smbus timeouts behind an axi4-lite slave
// assumes synchronous scl/sda samples and an external open-drain pad
//
// The register addresses and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module i2c_smbus_data_address_timeout
  import i2c_ext_pkg::*;
#(
  parameter int bit_divide = 100
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // address byte seen by the slave path
  input wire logic addr_strobe,
  input wire logic [7:0] addr_byte,
  // ack bit to drive at the ninth clock
  output logic ack_out
);
  typedef enum logic [1:0] {
    idle_s = 2'b00,
    addr_s = 2'b01,
    data_s = 2'b11,
    ackw_s = 2'b10
  } xfer_state_t;

  xfer_state_t state_reg, state_next;
  logic [7:0] amc_reg, amc_next;
  logic [7:0] smb_reg, smb_next;
  logic [7:0] sad_reg, sad_next;
  logic [7:0] slth_reg, slth_next;
  logic [7:0] sltl_reg, sltl_next;
  logic [7:0] ctl_reg, ctl_next;
  logic [7:0] own_reg, own_next;
  logic addressed_as_slave_reg, addressed_as_slave_next;
  logic iif_reg, iif_next;
  logic ack_reg, ack_next;
  logic aw_reg, aw_next;
  logic w_reg, w_next;
  logic [7:0] awa_reg, awa_next;
  logic [31:0] wd_reg, wd_next;
  logic bv_reg, bv_next;
  logic [1:0] br_reg, br_next;
  logic rv_reg, rv_next;
  logic [31:0] rd_reg, rd_next;
  logic [1:0] rr_reg, rr_next;
  logic [$clog2(bit_divide)-1:0] div_reg, div_next;

  logic wr_fire, rd_fire, scl_tick;
  logic start_tx, start_rx, sh_busy, sh_done, sh_sda;
  logic [7:0] rx_byte;
  logic low_hit, high_to, addr_match;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = a inside {data_io_port_off, address_mode_control_off,
      smbus_control_status_off, second_slave_address_off,
      scl_low_timeout_high_byte_off, scl_low_timeout_low_byte_off,
      bus_control_off, bus_status_off, own_address_off};
  endfunction : known_addr

  i2c_shift_unit u_shift (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_tick(scl_tick),
    .start_tx(start_tx),
    .start_rx(start_rx),
    .tx_byte(wd_reg[7:0]),
    .sda_in(sda_in),
    .busy(sh_busy),
    .done(sh_done),
    .rx_byte(rx_byte),
    .sda_out(sh_sda)
  );

  i2c_timeout_unit #(.count_width(16)) u_timeout (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .timeout_clock_select(smb_reg[timeout_clock_select_bit]),
    .low_timeout_value({slth_reg, sltl_reg}),
    .low_timeout_hit(low_hit),
    .high_timeout(high_to)
  );

  // axi handshakes
  assign s_axi_awready = ~aw_reg & ~bv_reg;
  assign s_axi_wready = ~w_reg & ~bv_reg;
  assign s_axi_arready = ~rv_reg;
  assign wr_fire = aw_reg & w_reg & ~bv_reg;
  assign rd_fire = s_axi_arvalid & ~rv_reg;
  assign scl_tick = (div_reg == '0);

  // slave address match
  always_comb begin
    addr_match = 1'b0;
    if (amc_reg[address_extension_bit]) begin
      addr_match = addr_byte[7:3] == ten_bit_prefix &&
        addr_byte[2:1] == amc_reg[2:1];
    end else begin
      addr_match = addr_byte[7:1] == own_reg[7:1];
    end
    if (amc_reg[general_call_enable_bit] && addr_byte == general_call_addr)
      addr_match = 1'b1;
    if (smb_reg[alert_response_enable_bit] &&
        addr_byte[7:1] == alert_response_addr)
      addr_match = 1'b1;
    if (smb_reg[second_address_enable_bit] &&
        addr_byte[7:1] == sad_reg[7:1])
      addr_match = 1'b1;
  end

  // data port triggers
  always_comb begin
    logic active;
    active = ctl_reg[master_select_bit] | addressed_as_slave_reg;
    start_tx = wr_fire && awa_reg == data_io_port_off && active &&
      ctl_reg[transmit_select_bit] && !sh_busy;
    start_rx = rd_fire && s_axi_araddr == data_io_port_off && active &&
      !ctl_reg[transmit_select_bit] && !sh_busy &&
      state_reg != ackw_s;
  end

  // bus and register state
  always_comb begin
    state_next = state_reg;
    amc_next = amc_reg;
    smb_next = smb_reg;
    sad_next = sad_reg;
    slth_next = slth_reg;
    sltl_next = sltl_reg;
    ctl_next = ctl_reg;
    own_next = own_reg;
    addressed_as_slave_next = addressed_as_slave_reg;
    iif_next = iif_reg;
    ack_next = ack_reg;
    div_next = (div_reg == $clog2(bit_divide)'(bit_divide - 1)) ?
      '0 : div_reg + 1'b1;
    // restart the divider so the first bit slot is full length
    if (start_tx || start_rx)
      div_next = $clog2(bit_divide)'(1);
    if (wr_fire) begin
      case (awa_reg)
        address_mode_control_off: amc_next = {wd_reg[7:6], 3'h0, wd_reg[2:0]};
        smbus_control_status_off: begin
          smb_next[7:4] = wd_reg[7:4];
          if (wd_reg[scl_low_timeout_flag_bit])
            smb_next[scl_low_timeout_flag_bit] = 1'b0;
        end
        second_slave_address_off: sad_next = {wd_reg[7:1], 1'b0};
        scl_low_timeout_high_byte_off: slth_next = wd_reg[7:0];
        scl_low_timeout_low_byte_off: sltl_next = wd_reg[7:0];
        bus_control_off: begin
          ctl_next = wd_reg[7:0] & 8'h0f;
          addressed_as_slave_next = 1'b0;
          if (wd_reg[master_select_bit] & ~ctl_reg[master_select_bit] ||
              wd_reg[repeat_start_request_bit])
            state_next = addr_s;
        end
        bus_status_off: begin
          if (wd_reg[interrupt_pending_flag_bit]) begin
            iif_next = 1'b0;
            smb_next[scl_low_timeout_flag_bit] = 1'b0;
          end
        end
        own_address_off: own_next = {wd_reg[7:1], 1'b0};
        default: ;
      endcase
    end
    ctl_next[repeat_start_request_bit] = 1'b0;
    // fast ack: software writes acknowledge_control to release the byte
    if (state_reg == ackw_s && wr_fire && awa_reg == bus_control_off) begin
      ack_next = wd_reg[acknowledge_control_bit];
      state_next = data_s;
    end
    if (start_tx && state_reg == addr_s)
      state_next = data_s;
    if (sh_done) begin
      iif_next = 1'b1;
      if (smb_reg[fast_ack_enable_bit] && !ctl_reg[transmit_select_bit] &&
          state_reg == data_s)
        state_next = ackw_s;
      else
        ack_next = ctl_reg[acknowledge_control_bit];
    end
    if (addr_strobe && addr_match) begin
      addressed_as_slave_next = 1'b1;
      iif_next = 1'b1;
    end
    if (low_hit) begin
      smb_next[scl_low_timeout_flag_bit] = 1'b1;
      iif_next = 1'b1;
    end
    smb_next[bus_high_timeout_flag_bit] = high_to;
    if (!ctl_reg[master_select_bit] && state_reg != idle_s && !addressed_as_slave_reg)
      state_next = idle_s;
  end

  // axi channel state
  always_comb begin
    aw_next = aw_reg | (s_axi_awvalid & s_axi_awready);
    w_next = w_reg | (s_axi_wvalid & s_axi_wready);
    awa_next = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awa_reg;
    wd_next = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wd_reg;
    bv_next = bv_reg;
    br_next = br_reg;
    rv_next = rv_reg;
    rd_next = rd_reg;
    rr_next = rr_reg;
    if (wr_fire) begin
      aw_next = 1'b0;
      w_next = 1'b0;
      bv_next = 1'b1;
      br_next = known_addr(awa_reg) ? axi_okay : axi_slverr;
    end else if (bv_reg && s_axi_bready) begin
      bv_next = 1'b0;
    end
    if (rd_fire) begin
      rv_next = 1'b1;
      rr_next = known_addr(s_axi_araddr) ? axi_okay : axi_slverr;
      case (s_axi_araddr)
        data_io_port_off: rd_next = {24'h0, rx_byte};
        address_mode_control_off: rd_next = {24'h0, amc_reg};
        smbus_control_status_off: rd_next = {24'h0, smb_reg};
        second_slave_address_off: rd_next = {24'h0, sad_reg};
        scl_low_timeout_high_byte_off: rd_next = {24'h0, slth_reg};
        scl_low_timeout_low_byte_off: rd_next = {24'h0, sltl_reg};
        bus_control_off: rd_next = {24'h0, ctl_reg};
        bus_status_off: rd_next = {24'h0, 1'b0, addressed_as_slave_reg, 4'h0,
          iif_reg, ack_reg};
        own_address_off: rd_next = {24'h0, own_reg};
        default: rd_next = 32'h0;
      endcase
    end else if (rv_reg && s_axi_rready) begin
      rv_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= idle_s;
      amc_reg <= ctrl_reset;
      smb_reg <= ctrl_reset;
      sad_reg <= ctrl_reset;
      slth_reg <= ctrl_reset;
      sltl_reg <= ctrl_reset;
      ctl_reg <= ctrl_reset;
      own_reg <= ctrl_reset;
      addressed_as_slave_reg <= 1'b0;
      iif_reg <= 1'b0;
      ack_reg <= 1'b0;
      div_reg <= '0;
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awa_reg <= 8'h00;
      wd_reg <= 32'h0;
      bv_reg <= 1'b0;
      br_reg <= axi_okay;
      rv_reg <= 1'b0;
      rd_reg <= 32'h0;
      rr_reg <= axi_okay;
    end else begin
      state_reg <= state_next;
      amc_reg <= amc_next;
      smb_reg <= smb_next;
      sad_reg <= sad_next;
      slth_reg <= slth_next;
      sltl_reg <= sltl_next;
      ctl_reg <= ctl_next;
      own_reg <= own_next;
      addressed_as_slave_reg <= addressed_as_slave_next;
      iif_reg <= iif_next;
      ack_reg <= ack_next;
      div_reg <= div_next;
      aw_reg <= aw_next;
      w_reg <= w_next;
      awa_reg <= awa_next;
      wd_reg <= wd_next;
      bv_reg <= bv_next;
      br_reg <= br_next;
      rv_reg <= rv_next;
      rd_reg <= rd_next;
      rr_reg <= rr_next;
    end
  end

  assign s_axi_bvalid = bv_reg;
  assign s_axi_bresp = br_reg;
  assign s_axi_rvalid = rv_reg;
  assign s_axi_rdata = rd_reg;
  assign s_axi_rresp = rr_reg;
  assign sda_out = 1'b0;
  assign sda_oe = sh_sda;
  assign ack_out = ack_reg;
endmodule : i2c_smbus_data_address_timeout

/* core/i2c_ext_pkg.sv */
// constants for the data port, address-mode and smbus extension block
// assumes a 32-bit axi4-lite slave with one aligned word per register
package i2c_ext_pkg;
  // register byte offsets
  localparam logic [7:0] data_io_port_off = 8'h00;
  localparam logic [7:0] address_mode_control_off = 8'h04;
  localparam logic [7:0] smbus_control_status_off = 8'h08;
  localparam logic [7:0] second_slave_address_off = 8'h0c;
  localparam logic [7:0] scl_low_timeout_high_byte_off = 8'h10;
  localparam logic [7:0] scl_low_timeout_low_byte_off = 8'h14;
  localparam logic [7:0] bus_control_off = 8'h18;
  localparam logic [7:0] bus_status_off = 8'h1c;
  localparam logic [7:0] own_address_off = 8'h20;
  // address_mode_control fields
  localparam int general_call_enable_bit = 7;
  localparam int address_extension_bit = 6;
  localparam int upper_address_lsb = 0;
  // smbus_control_status fields
  localparam int fast_ack_enable_bit = 7;
  localparam int alert_response_enable_bit = 6;
  localparam int second_address_enable_bit = 5;
  localparam int timeout_clock_select_bit = 4;
  localparam int scl_low_timeout_flag_bit = 3;
  localparam int bus_high_timeout_flag_bit = 2;
  // bus_control fields
  localparam int master_select_bit = 0;
  localparam int transmit_select_bit = 1;
  localparam int acknowledge_control_bit = 2;
  localparam int repeat_start_request_bit = 3;
  // bus_status fields
  localparam int interrupt_pending_flag_bit = 1;
  localparam int addressed_as_slave_bit = 6;
  // reset value and fixed bus addresses
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [7:0] general_call_addr = 8'h00;
  localparam logic [6:0] alert_response_addr = 7'h0c;
  localparam logic [4:0] ten_bit_prefix = 5'h1e;
  // timing and axi response codes
  localparam int timeout_prescale = 64;
  localparam int high_timeout_shift = 9;
  localparam logic [1:0] axi_okay = 2'h0;
  localparam logic [1:0] axi_slverr = 2'h2;
endpackage : i2c_ext_pkg

/* core/i2c_shift_unit.sv */
// byte shifter: sends or receives one byte msb first on the bus
// assumes scl_tick pulses once per bit slot from the parent
`timescale 1ns/1ps
module i2c_shift_unit
  import i2c_ext_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // control
  input wire logic scl_tick,
  input wire logic start_tx,
  input wire logic start_rx,
  input wire logic [7:0] tx_byte,
  input wire logic sda_in,
  // results
  output logic busy,
  output logic done,
  output logic [7:0] rx_byte,
  output logic sda_out
);
  logic [7:0] shift_reg, shift_next;
  logic [3:0] count_reg, count_next;
  logic dir_reg, dir_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic [7:0] rx_reg, rx_next;

  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    dir_next = dir_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    rx_next = rx_reg;
    if (!busy_reg && (start_tx || start_rx)) begin
      busy_next = 1'b1;
      dir_next = start_tx;
      shift_next = start_tx ? tx_byte : 8'h00;
      count_next = 4'h0;
    end else if (busy_reg && scl_tick) begin
      shift_next = {shift_reg[6:0], sda_in};
      count_next = count_reg + 4'h1;
      if (count_reg == 4'h7) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        if (!dir_reg) begin
          rx_next = {shift_reg[6:0], sda_in};
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 8'h00;
      count_reg <= 4'h0;
      dir_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      rx_reg <= 8'h00;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      dir_reg <= dir_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      rx_reg <= rx_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
  assign rx_byte = rx_reg;
  assign sda_out = busy_reg & dir_reg & ~shift_reg[7];
endmodule : i2c_shift_unit

/* core/i2c_timeout_unit.sv */
// scl low and bus free timeout counters
// assumes scl and sda are already synchronous samples of the bus
`timescale 1ns/1ps
module i2c_timeout_unit
  import i2c_ext_pkg::*;
#(
  parameter int count_width = 16
)
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // bus levels and settings
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic timeout_clock_select,
  input wire logic [15:0] low_timeout_value,
  // events
  output logic low_timeout_hit,
  output logic high_timeout
);
  logic [5:0] pre_reg, pre_next;
  logic [count_width-1:0] low_reg, low_next;
  logic [count_width-1:0] high_reg, high_next;
  logic hit_reg, hit_next;
  logic tick;
  logic [15:0] high_limit;

  assign high_limit = low_timeout_value >> high_timeout_shift;
  assign tick = timeout_clock_select | (pre_reg == 6'(timeout_prescale - 1));

  always_comb begin
    pre_next = (pre_reg == 6'(timeout_prescale - 1)) ? 6'h00 : pre_reg + 6'h01;
    low_next = low_reg;
    high_next = high_reg;
    hit_next = 1'b0;
    if (scl_in || low_timeout_value == 16'h0000) begin
      low_next = '0;
    end else if (tick && low_reg != {count_width{1'b1}}) begin
      low_next = low_reg + 1'b1;
      hit_next = (low_reg + 1'b1) == count_width'(low_timeout_value);
    end
    if (!scl_in || !sda_in) begin
      high_next = '0;
    end else if (tick && high_reg != {count_width{1'b1}}) begin
      high_next = high_reg + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_reg <= 6'h00;
      low_reg <= '0;
      high_reg <= '0;
      hit_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      low_reg <= low_next;
      high_reg <= high_next;
      hit_reg <= hit_next;
    end
  end

  assign low_timeout_hit = hit_reg;
  assign high_timeout = (high_reg > count_width'(high_limit));
endmodule : i2c_timeout_unit

/* dv/i2c_smbus_data_address_timeout_assertions.sv */
// checker for the axi4-lite side of the data port and smbus block
// assumes binding onto the block's top module, one clock domain
`timescale 1ns/1ps
module i2c_ext_assertions
  import i2c_ext_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WRITE_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response missing");
  AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_WRITE_UNMAPPED: assert property (wr_taken ##0
    (s_axi_awaddr > own_address_off) |-> ##2 s_axi_bresp == axi_slverr)
    else $error("unmapped write not refused");
  AST_WRITE_REFUSE: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  AST_READ_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data missing");
  AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped");
  AST_READ_UNMAPPED: assert property (rd_taken ##0
    (s_axi_araddr > own_address_off)
    |=> s_axi_rresp == axi_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_READ_UPPER: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_READ_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
endmodule : i2c_ext_assertions

/* dv/i2c_bus_peer.sv */
// other masters and slaves on the two-wire bus, behavioural
// assumes open-drain sda with pull-up, scl idle high
`timescale 1ns/1ps
module i2c_bus_peer (
  // clock
  input wire logic ref_clk,
  // design side
  input wire logic sda_oe,
  // bus levels and calling address
  output logic scl_in,
  output logic sda_in,
  output logic addr_strobe,
  output logic [7:0] addr_byte
);
  logic sda_low = 1'b0;
  initial begin
    scl_in = 1'b1;
    addr_strobe = 1'b0;
    addr_byte = 8'h00;
  end
  // wired and: either side pulling low wins
  assign sda_in = !(sda_oe || sda_low);
  task automatic hold_scl(input int n);
    @(posedge ref_clk) scl_in <= 1'b0;
    repeat (n) @(posedge ref_clk);
    scl_in <= 1'b1;
  endtask : hold_scl
  task automatic pull_sda(input logic low);
    @(posedge ref_clk) sda_low <= low;
  endtask : pull_sda
  // calling address with r/w in bit 0
  task automatic call(input logic [7:0] a);
    @(posedge ref_clk) addr_strobe <= 1'b1;
    addr_byte <= a;
    @(posedge ref_clk) addr_strobe <= 1'b0;
    addr_byte <= ~a;
  endtask : call
endmodule : i2c_bus_peer

/* dv/i2c_smbus_data_address_timeout_bench.sv */
// bench: registers, byte shifting, address match and timeouts
// assumes the peer model in dv/ and bit_divide set to 4
`timescale 1ns/1ps
module i2c_smbus_data_address_timeout_bench;
  import i2c_ext_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic scl_in;
  logic sda_in;
  logic sda_oe;
  logic addr_strobe;
  logic [7:0] addr_byte;
  logic [3:0] wstrb = 4'hf;
  logic sda_out;
  logic ack_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  i2c_smbus_data_address_timeout #(.bit_divide(4)) u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strobe(addr_strobe), .addr_byte(addr_byte), .ack_out(ack_out)
  );
  i2c_bus_peer u_peer (
    .ref_clk(ref_clk), .sda_oe(sda_oe), .scl_in(scl_in),
    .sda_in(sda_in), .addr_strobe(addr_strobe), .addr_byte(addr_byte)
  );
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    #1;
    while (awvalid || wvalid) begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      #1;
    end
    @(posedge ref_clk) bready <= 1'b1;
    do @(posedge ref_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_val({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge ref_clk) rready <= 1'b1;
    do @(posedge ref_clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check_val({r, d[29:0] & {22'h0, m}}, {axi_okay, 22'h0, e});
  endtask : rchk
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 1; i < 6; i++) rchk(8'(i * 4), 8'hfb, ctrl_reset);
    wr(address_mode_control_off, 8'hc5, axi_okay);
    rchk(address_mode_control_off, 8'hff, 8'hc5);
    wr(second_slave_address_off, 8'ha4, axi_okay);
    rchk(second_slave_address_off, 8'hfe, 8'ha4);
    wr(scl_low_timeout_high_byte_off, 8'h5a, axi_okay);
    wr(scl_low_timeout_low_byte_off, 8'h3c, axi_okay);
    rchk(scl_low_timeout_high_byte_off, 8'hff, 8'h5a);
    rchk(scl_low_timeout_low_byte_off, 8'hff, 8'h3c);
    wr(scl_low_timeout_high_byte_off, 8'h00, axi_okay);
    wr(8'h40, 8'h11, axi_slverr);
    rd(8'h40, d, r);
    check_val({r, d[29:0]}, {axi_slverr, 30'h0});
    $display("t_regs done");
  endtask : t_regs
  task automatic t_tx(input logic [7:0] c, input logic [7:0] b,
                      input logic early);
    int n;
    int f;
    n = 0;
    f = 99;
    wr(bus_control_off, c, axi_okay);
    fork
      wr(data_io_port_off, b, axi_okay);
      for (int i = 0; i < 48; i++) begin
        @(posedge ref_clk);
        if (sda_oe === 1'b1) n++;
        if (sda_oe === 1'b1 && f == 99) f = i;
      end
    join
    check_val({31'h0, sda_out}, 32'h0);
    check_val(32'(n), 32'd16);
    check_val({31'h0, f < 10}, {31'h0, early});
    $display("t_tx done");
  endtask : t_tx
  task automatic t_rx;
    wr(bus_control_off, 8'h01, axi_okay);
    u_peer.pull_sda(1'b1);
    rchk(data_io_port_off, 8'h00, 8'h00);
    repeat (48) @(posedge ref_clk);
    u_peer.pull_sda(1'b0);
    rchk(data_io_port_off, 8'hff, 8'h00);
    repeat (48) @(posedge ref_clk);
    wr(bus_control_off, 8'h03, axi_okay); // mode first
    rchk(data_io_port_off, 8'hff, 8'hff);
    u_peer.pull_sda(1'b1);
    repeat (48) @(posedge ref_clk);
    rchk(data_io_port_off, 8'hff, 8'hff);
    u_peer.pull_sda(1'b0);
    wr(data_io_port_off, 8'h3c, axi_okay);
    repeat (48) @(posedge ref_clk);
    rchk(data_io_port_off, 8'hff, 8'hff);
    $display("t_rx done");
  endtask : t_rx
  task automatic t_slave;
    logic [24:0] c [9];
    c = '{{8'h00, 8'h20, 8'ha4, 1'b1}, {8'h00, 8'h00, 8'ha4, 1'b0},
          {8'h00, 8'h40, 8'h19, 1'b1}, {8'h00, 8'h00, 8'h19, 1'b0},
          {8'h80, 8'h00, 8'h00, 1'b1}, {8'h00, 8'h00, 8'h00, 1'b0},
          {8'h00, 8'h00, 8'h6a, 1'b1}, {8'h40, 8'h00, 8'h6a, 1'b0},
          {8'h45, 8'h00, 8'hf4, 1'b1}};
    wr(second_slave_address_off, 8'ha4, axi_okay);
    wr(own_address_off, 8'h6a, axi_okay);
    foreach (c[i]) begin
      wr(address_mode_control_off, c[i][24:17], axi_okay);
      wr(smbus_control_status_off, c[i][16:9], axi_okay);
      wr(bus_control_off, 8'h00, axi_okay);
      u_peer.call(c[i][8:1]);
      rchk(bus_status_off, 8'h40, {1'b0, c[i][0], 6'h0});
    end
    $display("t_slave done");
  endtask : t_slave
  task automatic t_timeout;
    wr(scl_low_timeout_low_byte_off, 8'h20, axi_okay);
    wr(smbus_control_status_off, 8'h10, axi_okay);
    wr(bus_status_off, 8'h02, axi_okay);
    u_peer.hold_scl(20);
    u_peer.hold_scl(20);
    rchk(smbus_control_status_off, 8'h08, 8'h00);
    u_peer.hold_scl(40);
    rchk(smbus_control_status_off, 8'h08, 8'h08);
    rchk(bus_status_off, 8'h02, 8'h02);
    wr(smbus_control_status_off, 8'h18, axi_okay);
    rchk(smbus_control_status_off, 8'h08, 8'h00);
    wr(scl_low_timeout_low_byte_off, 8'h00, axi_okay);
    u_peer.hold_scl(80);
    rchk(smbus_control_status_off, 8'h08, 8'h00);
    wr(smbus_control_status_off, 8'h00, axi_okay);
    wr(scl_low_timeout_low_byte_off, 8'h02, axi_okay);
    u_peer.hold_scl(40);
    rchk(smbus_control_status_off, 8'h08, 8'h00);
    u_peer.hold_scl(140);
    rchk(smbus_control_status_off, 8'h08, 8'h08);
    wr(bus_status_off, 8'h02, axi_okay);
    rchk(smbus_control_status_off, 8'h08, 8'h00);
    // divided clock stays selected while the high flag is watched
    wr(scl_low_timeout_high_byte_off, 8'h04, axi_okay);
    repeat (260) @(posedge ref_clk);
    rchk(smbus_control_status_off, 8'h04, 8'h04);
    u_peer.pull_sda(1'b1);
    @(posedge ref_clk);
    rchk(smbus_control_status_off, 8'h04, 8'h00);
    u_peer.pull_sda(1'b0);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_ack;
    wr(smbus_control_status_off, 8'h80, axi_okay);
    wr(bus_control_off, 8'h03, axi_okay);
    wr(data_io_port_off, 8'ha5, axi_okay);
    repeat (48) @(posedge ref_clk);
    wr(bus_control_off, 8'h05, axi_okay);
    rchk(data_io_port_off, 8'h00, 8'h00);
    repeat (48) @(posedge ref_clk);
    check_val({31'h0, ack_out}, 32'h0);
    wr(bus_control_off, 8'h05, axi_okay);
    check_val({31'h0, ack_out}, 32'h1);
    wr(smbus_control_status_off, 8'h00, axi_okay);
    wr(bus_control_off, 8'h01, axi_okay);
    rchk(data_io_port_off, 8'hff, 8'hff);
    repeat (48) @(posedge ref_clk);
    check_val({31'h0, ack_out}, 32'h0);
    $display("t_ack done");
  endtask : t_ack
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_tx(8'h0b, 8'h0f, 1'b1);
    t_tx(8'h03, 8'hf0, 1'b0);
    t_rx();
    t_slave();
    t_timeout();
    t_ack();
    test_done();
  end
endmodule : i2c_smbus_data_address_timeout_bench
bind i2c_smbus_data_address_timeout i2c_ext_assertions u_chk (.*);
